// [common/lt_pkg.sv]
// Constants, types and the notes on behaviour for the logic tile.
// Assumes a single clock domain and a synchronous, active-high reset.
// Notes on behaviour
// RULE1: Each product-term array takes twelve routed inputs into eight product terms.
// RULE2: A product term ANDs any chosen subset of inputs, one to twelve.
// RULE3: Each used input enters a product term true or inverted, per configuration.
// RULE4: Each array output ORs a chosen set of one to eight terms.
// RULE5: Every output of an array can use any of the eight terms.
// RULE6: Two arrays exist; each output is registered or combinational by configuration.
// RULE7: Array inputs and outputs are interchangeable; any function fits any position.
// RULE8: An eight-bit ALU finishes every operation in one clock cycle.
// RULE9: Compare and condition logic derive status from the working registers.
// RULE10: Six working registers are readable and writable by CPU or DMA. Here queue 0 is write-only and queue 1 read-only from the port.
// RULE11: Accumulators feed the ALU, receive its result, and feed the compares.
// RULE12: Data registers feed the ALU and feed the compares.
// RULE13: Two four-byte queues are the parallel path between bus and datapath.
// RULE14: A queue loads data registers or accumulators, or captures accumulator or ALU.
// RULE15: A configuration memory holds eight independent sixteen-bit datapath configurations.
// RULE16: The configuration address picks the active function, changeable every cycle.
// RULE17: Configuration address comes from any routed source: arrays, pins, datapaths.
// RULE18: The ALU offers increment, decrement, add, subtract, AND, OR, XOR, pass.
// RULE19: Pass forwards an operand unchanged toward shifter, mask or working register. No shifter or mask here; it feeds accumulators, queue 1, alu_out.
// RULE20: A status and control unit lets firmware write control and read status.
// RULE21: A clock and reset unit selects the clock and reset for tile logic.
// RULE22: The configuration address is three bits and takes effect the same cycle.
// RULE23: Queues flag full and empty, drop writes when full, read oldest first.
package lt_pkg;
	localparam int ARR_IN = 12;
	localparam int ARR_PT = 8;
	localparam int ARR_OUT = 4;
	localparam int DW = 8;
	localparam int CFG_DEPTH = 8;
	localparam int CFG_AW = 3;
	localparam int CFG_W = 16;
	localparam int Q_DEPTH = 4;
	// Working, control and status register select codes on the register port.
	localparam logic [3:0] REG_ACC0 = 4'h0;
	localparam logic [3:0] REG_ACC1 = 4'h1;
	localparam logic [3:0] REG_DAT0 = 4'h2;
	localparam logic [3:0] REG_DAT1 = 4'h3;
	localparam logic [3:0] REG_Q0 = 4'h4;
	localparam logic [3:0] REG_Q1 = 4'h5;
	localparam logic [3:0] REG_CTRL = 4'h6;
	localparam logic [3:0] REG_STAT = 4'h7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Configuration word fields.
	localparam int F_OP = 0;
	localparam int F_SRCA = 3;
	localparam int F_SRCB = 4;
	localparam int F_DST = 6;
	localparam int F_Q0LD = 8;
	localparam int F_Q1CAP = 10;
	localparam int F_Q0RD = 12;
	localparam int F_Q1WR = 13;
	localparam logic [15:0] CFG_RST = 16'h0000;
	typedef enum logic [2:0] {
		OP_PASS = 3'b000,
		OP_INC = 3'b001,
		OP_DEC = 3'b010,
		OP_ADD = 3'b011,
		OP_SUB = 3'b100,
		OP_AND = 3'b101,
		OP_OR = 3'b110,
		OP_XOR = 3'b111
	} lt_op_t;
endpackage

// [logic/lt_queue.sv]
// Small FIFO with valid and ready on both sides.
// Assumes one clock; writes while full are not accepted.
`timescale 1ns/1ps
module lt_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out,
	output logic full_out,
	output logic empty_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	assign full_out = (cnt_r == (AW+1)'(DEPTH));
	assign empty_out = (cnt_r == '0);
	assign in_ready_out = !full_out;
	assign out_valid_out = !empty_out;
	assign out_data_out = mem_r[rp_r];
	assign push = in_valid_in && !full_out; // see RULE23
	assign pop = out_ready_in && !empty_out;
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wp_r] <= in_data_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1; // see RULE23
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // lt_queue

// [logic/lt_tile.sv]
// Logic tile: two product-term arrays, an 8-bit datapath and its register port.
// Assumes the routing matrix and the CPU/DMA port run on clk_in; pins are synchronised here.
`timescale 1ns/1ps
module lt_tile (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic tile_clk_en_in,
	input wire logic tile_rst_in,
	input wire logic [11:0] arr0_in,
	input wire logic [11:0] arr1_in,
	input wire logic [2:0] route_addr_in,
	input wire logic [2:0] pin_addr_in,
	input wire logic [1:0] addr_src_in,
	input wire logic [7:0] pt_wr_in,
	input wire logic [3:0] pt_idx_in,
	input wire logic [23:0] pt_cfg_in,
	input wire logic [7:0] or_cfg_in,
	input wire logic reg_out_cfg_in,
	input wire logic cfg_wr_in,
	input wire logic [2:0] cfg_waddr_in,
	input wire logic [15:0] cfg_wdata_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [3:0] bus_sel_in,
	input wire logic [7:0] bus_wdata_in,
	output logic [7:0] bus_rdata_out,
	output logic bus_ack_out,
	output logic [3:0] arr0_out,
	output logic [3:0] arr1_out,
	output logic [7:0] alu_out,
	output logic [2:0] cfg_addr_out,
	output logic cmp_eq_out,
	output logic cmp_lt_out,
	output logic zero_out,
	output logic q0_full_out,
	output logic q0_empty_out,
	output logic q1_full_out,
	output logic q1_empty_out
);
	// Product-term configuration: per array 8 terms, each 12 use bits and 12 invert bits.
	logic [23:0] pt_r [2][8];
	logic [7:0] or_r [2][4];
	logic [3:0] regsel_r [2];
	logic [3:0] arr_q_r [2];
	logic [3:0] arr_c [2];
	logic [15:0] cfg_mem_r [lt_pkg::CFG_DEPTH];
	logic [7:0] acc0_r;
	logic [7:0] acc1_r;
	logic [7:0] dat0_r;
	logic [7:0] dat1_r;
	logic [7:0] ctrl_r;
	logic [7:0] rdata_r;
	logic ack_r;
	logic [2:0] p1_r;
	logic [2:0] p2_r;
	logic [2:0] p3_r;
	logic [2:0] pin_addr;
	logic [2:0] cfg_addr;
	logic [15:0] cfg;
	logic [7:0] opa;
	logic [7:0] opb;
	logic [7:0] alu;
	logic run;
	logic q0_wvalid;
	logic [7:0] q0_wdata;
	logic q0_rvalid;
	logic q0_rready;
	logic [7:0] q0_rdata;
	logic q1_wvalid;
	logic [7:0] q1_wdata;
	logic q1_rvalid;
	logic q1_rready;
	logic [7:0] q1_rdata;
	logic q0_full;
	logic q1_full;

	// One product term: AND over used inputs, each taken true or inverted.
	// A term with no use bits set is true, so unused terms must stay out of the OR masks.
	function automatic logic pterm(input logic [11:0] x, input logic [23:0] c);
		logic r;
		r = 1'b1;
		for (int i = 0; i < lt_pkg::ARR_IN; i++) begin
			if (c[i]) begin
				r = r & (x[i] ^ c[12 + i]); // see RULE2 see RULE3
			end
		end
		return r;
	endfunction

	// Arithmetic wraps modulo 256; no carry leaves the tile.
	function automatic logic [7:0] alu_fn(input logic [2:0] op, input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] r;
		r = a;
		case (op)
			lt_pkg::OP_INC: r = a + 8'h01;
			lt_pkg::OP_DEC: r = a - 8'h01;
			lt_pkg::OP_ADD: r = a + b;
			lt_pkg::OP_SUB: r = a - b;
			lt_pkg::OP_AND: r = a & b;
			lt_pkg::OP_OR: r = a | b;
			lt_pkg::OP_XOR: r = a ^ b;
			default: r = a; // see RULE19
		endcase
		return r; // see RULE18
	endfunction

	// Array configuration store; the same term set serves all four outputs.
	// An output write updates its OR mask and its register select together, so the two
	// never disagree for a cycle.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int a = 0; a < 2; a++) begin
				regsel_r[a] <= 4'h0;
				for (int t = 0; t < lt_pkg::ARR_PT; t++) begin
					pt_r[a][t] <= 24'h00_0000;
				end
				for (int o = 0; o < lt_pkg::ARR_OUT; o++) begin
					or_r[a][o] <= 8'h00;
				end
			end
		end else begin
			for (int a = 0; a < 2; a++) begin
				if (pt_wr_in[a*4 +: 4] != 4'h0) begin
					if (pt_idx_in[3] == 1'b0) begin
						pt_r[a][pt_idx_in[2:0]] <= pt_cfg_in;
					end else begin
						or_r[a][pt_idx_in[1:0]] <= or_cfg_in;
						regsel_r[a][pt_idx_in[1:0]] <= reg_out_cfg_in; // see RULE6
					end
				end
			end
		end
	end

	always_comb begin
		for (int a = 0; a < 2; a++) begin
			for (int o = 0; o < lt_pkg::ARR_OUT; o++) begin
				arr_c[a][o] = 1'b0;
				for (int t = 0; t < lt_pkg::ARR_PT; t++) begin
					if (or_r[a][o][t]) begin
						arr_c[a][o] = arr_c[a][o] | pterm(a == 0 ? arr0_in : arr1_in,
							pt_r[a][t]); // see RULE1 see RULE4 see RULE5 see RULE7
					end
				end
			end
		end
	end

	// The registered copies hold while the tile is stopped, so a stopped state machine
	// keeps its state until it runs again.
	always_ff @(posedge clk_in) begin
		if (rst_in || tile_rst_in) begin
			arr_q_r[0] <= 4'h0;
			arr_q_r[1] <= 4'h0;
		end else if (run) begin
			arr_q_r[0] <= arr_c[0];
			arr_q_r[1] <= arr_c[1];
		end
	end

	always_comb begin
		for (int o = 0; o < lt_pkg::ARR_OUT; o++) begin
			arr0_out[o] = regsel_r[0][o] ? arr_q_r[0][o] : arr_c[0][o]; // see RULE6
			arr1_out[o] = regsel_r[1][o] ? arr_q_r[1][o] : arr_c[1][o];
		end
	end

	// Pin address passes three flops; it changes once the last two agree.
	// A pin address that flickers between edges is ignored until it has stood for two
	// samples, which also keeps a half-settled code off the configuration memory.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			p1_r <= 3'h0;
			p2_r <= 3'h0;
			p3_r <= 3'h0;
			pin_addr <= 3'h0;
		end else begin
			p1_r <= pin_addr_in;
			p2_r <= p1_r;
			p3_r <= p2_r;
			if (p2_r == p3_r) begin
				pin_addr <= p3_r;
			end
		end
	end

	// Address source: 0 routed, 1 array 0, 2 pins, 3 own ALU low bits.
	// Source 3 closes a loop through the configuration memory; alu_out is registered,
	// so the loop always holds one flop and never forms a combinational ring.
	always_comb begin
		case (addr_src_in)
			2'd1: cfg_addr = arr0_out[2:0];
			2'd2: cfg_addr = pin_addr;
			2'd3: cfg_addr = alu_out[2:0];
			default: cfg_addr = route_addr_in;
		endcase
	end // see RULE17

	assign cfg = cfg_mem_r[cfg_addr]; // see RULE15 see RULE16 see RULE22
	assign cfg_addr_out = cfg_addr;

	// A write to the entry that is active in the same cycle still sees the old word;
	// the new configuration applies from the next cycle on.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < lt_pkg::CFG_DEPTH; i++) begin
				cfg_mem_r[i] <= lt_pkg::CFG_RST;
			end
		end else if (cfg_wr_in) begin
			cfg_mem_r[cfg_waddr_in] <= cfg_wdata_in;
		end
	end

	// Clock gating is modelled as an enable from the control register and the select pin.
	assign run = tile_clk_en_in && ctrl_r[0]; // see RULE21

	// Operand B may also take either accumulator, so one accumulator can be combined
	// with the other without a round trip through a data register.
	assign opa = cfg[lt_pkg::F_SRCA] ? acc1_r : acc0_r; // see RULE11
	always_comb begin
		case (cfg[lt_pkg::F_SRCB +: 2])
			2'd0: opb = dat0_r; // see RULE12
			2'd1: opb = dat1_r;
			2'd2: opb = acc0_r;
			default: opb = acc1_r;
		endcase
	end
	assign alu = alu_fn(cfg[lt_pkg::F_OP +: 3], opa, opb); // see RULE8

	// Queue 0 carries bus writes into the datapath; queue 1 carries results to the bus.
	assign q0_wvalid = bus_wr_in && bus_sel_in == lt_pkg::REG_Q0;
	assign q0_wdata = bus_wdata_in;
	assign q0_rready = run && cfg[lt_pkg::F_Q0RD]; // see RULE13
	assign q1_wvalid = run && cfg[lt_pkg::F_Q1WR];
	assign q1_wdata = cfg[lt_pkg::F_Q1CAP] ? alu : acc0_r; // see RULE14
	assign q1_rready = bus_rd_in && bus_sel_in == lt_pkg::REG_Q1;

	// Write-side ready is left unused: a bus write to a full queue is dropped, and
	// firmware is expected to watch the full flag in the status register.
	lt_queue #(.WIDTH(lt_pkg::DW), .DEPTH(lt_pkg::Q_DEPTH)) u_q0 (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_valid_in(q0_wvalid),
		.in_ready_out(),
		.in_data_in(q0_wdata),
		.out_valid_out(q0_rvalid),
		.out_ready_in(q0_rready),
		.out_data_out(q0_rdata),
		.full_out(q0_full),
		.empty_out(q0_empty_out)
	);
	lt_queue #(.WIDTH(lt_pkg::DW), .DEPTH(lt_pkg::Q_DEPTH)) u_q1 (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_valid_in(q1_wvalid),
		.in_ready_out(),
		.in_data_in(q1_wdata),
		.out_valid_out(q1_rvalid),
		.out_ready_in(q1_rready),
		.out_data_out(q1_rdata),
		.full_out(q1_full),
		.empty_out(q1_empty_out)
	);
	assign q0_full_out = q0_full;
	assign q1_full_out = q1_full;

	// Working registers: bus writes take priority over datapath updates.
	// Where a queue load and an ALU result aim at the same accumulator, the queue load
	// wins because it is assigned last.
	always_ff @(posedge clk_in) begin
		if (rst_in || tile_rst_in) begin
			acc0_r <= lt_pkg::RST_BYTE;
			acc1_r <= lt_pkg::RST_BYTE;
		end else if (bus_wr_in && bus_sel_in == lt_pkg::REG_ACC0) begin
			acc0_r <= bus_wdata_in; // see RULE10
		end else if (bus_wr_in && bus_sel_in == lt_pkg::REG_ACC1) begin
			acc1_r <= bus_wdata_in;
		end else if (run) begin
			case (cfg[lt_pkg::F_DST +: 2])
				2'd1: acc0_r <= alu; // see RULE11
				2'd2: acc1_r <= alu;
				default: ;
			endcase
			if (cfg[lt_pkg::F_Q0LD +: 2] == 2'd2 && q0_rvalid && q0_rready) begin
				acc0_r <= q0_rdata; // see RULE14
			end
			if (cfg[lt_pkg::F_Q0LD +: 2] == 2'd3 && q0_rvalid && q0_rready) begin
				acc1_r <= q0_rdata;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || tile_rst_in) begin
			dat0_r <= lt_pkg::RST_BYTE;
			dat1_r <= lt_pkg::RST_BYTE;
		end else if (bus_wr_in && bus_sel_in == lt_pkg::REG_DAT0) begin
			dat0_r <= bus_wdata_in; // see RULE10
		end else if (bus_wr_in && bus_sel_in == lt_pkg::REG_DAT1) begin
			dat1_r <= bus_wdata_in;
		end else if (run && q0_rvalid && q0_rready) begin
			if (cfg[lt_pkg::F_Q0LD +: 2] == 2'd0) begin
				dat0_r <= q0_rdata; // see RULE14
			end else if (cfg[lt_pkg::F_Q0LD +: 2] == 2'd1) begin
				dat1_r <= q0_rdata;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_r <= lt_pkg::RST_BYTE;
		end else if (bus_wr_in && bus_sel_in == lt_pkg::REG_CTRL) begin
			ctrl_r <= bus_wdata_in; // see RULE20
		end
	end

	// Read path: one-cycle registered answer; unmapped selects read zero.
	// A read of queue 1 pops it in the cycle that captures the data, so the answer
	// always carries the byte that was removed.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_r <= 8'h00;
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_rd_in || bus_wr_in;
			if (bus_rd_in) begin
				if (bus_sel_in == lt_pkg::REG_ACC0) begin
					rdata_r <= acc0_r;
				end else if (bus_sel_in == lt_pkg::REG_ACC1) begin
					rdata_r <= acc1_r;
				end else if (bus_sel_in == lt_pkg::REG_DAT0) begin
					rdata_r <= dat0_r;
				end else if (bus_sel_in == lt_pkg::REG_DAT1) begin
					rdata_r <= dat1_r;
				end else if (bus_sel_in == lt_pkg::REG_Q1) begin
					rdata_r <= q1_rvalid ? q1_rdata : 8'h00;
				end else if (bus_sel_in == lt_pkg::REG_CTRL) begin
					rdata_r <= ctrl_r;
				end else if (bus_sel_in == lt_pkg::REG_STAT) begin
					rdata_r <= {q1_empty_out, q1_full, q0_empty_out, q0_full,
						1'b0, zero_out, cmp_lt_out, cmp_eq_out}; // see RULE20
				end else begin
					rdata_r <= 8'h00;
				end
			end
		end
	end
	assign bus_rdata_out = rdata_r;
	assign bus_ack_out = ack_r;

	// Datapath outputs and conditions are registered.
	// They follow the active entry even while the tile is stopped.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			alu_out <= 8'h00;
			cmp_eq_out <= 1'b0;
			cmp_lt_out <= 1'b0;
			zero_out <= 1'b0;
		end else begin
			alu_out <= alu;
			cmp_eq_out <= (opa == opb); // see RULE9
			cmp_lt_out <= (opa < opb);
			zero_out <= (alu == 8'h00);
		end
	end
endmodule // lt_tile

// [testbench/lt_tile_asserts.sv]
// Port assertions for the logic tile, bound to lt_tile.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module lt_tile_asserts (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic bus_ack_out,
	input wire logic [1:0] addr_src_in,
	input wire logic [2:0] route_addr_in,
	input wire logic [2:0] cfg_addr_out,
	input wire logic [3:0] arr0_out,
	input wire logic [7:0] alu_out,
	input wire logic q0_full_out,
	input wire logic q0_empty_out,
	input wire logic q1_full_out,
	input wire logic q1_empty_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	AST_ACK: assert property ((bus_rd_in || bus_wr_in) |=> bus_ack_out)
		else $error("ack missing after request");
	AST_NOACK: assert property (!(bus_rd_in || bus_wr_in) |=> !bus_ack_out)
		else $error("ack without request");
	AST_ROUTE: assert property (addr_src_in == 2'h0 |-> cfg_addr_out == route_addr_in)
		else $error("routed address not selected");
	AST_ARRSEL: assert property (addr_src_in == 2'h1 |-> cfg_addr_out == arr0_out[2:0])
		else $error("array address not selected");
	AST_ALUSEL: assert property (addr_src_in == 2'h3 |-> cfg_addr_out == alu_out[2:0])
		else $error("datapath address not selected");
	AST_Q0FLAGS: assert property (!(q0_full_out && q0_empty_out))
		else $error("queue zero full and empty");
	AST_Q1FLAGS: assert property (!(q1_full_out && q1_empty_out))
		else $error("queue one full and empty");
	AST_RSTQ: assert property ($past(rst_in) |-> q0_empty_out && q1_empty_out)
		else $error("queues not empty after reset");
	cover property (bus_rd_in ##1 bus_ack_out);
	cover property (addr_src_in == 2'h3);
	cover property (q0_full_out ##1 q1_full_out [*1]);
endmodule // lt_tile_asserts
bind lt_tile lt_tile_asserts i_lt_tile_asserts (.clk_in, .rst_in, .bus_wr_in, .bus_rd_in,
	.bus_ack_out, .addr_src_in, .route_addr_in, .cfg_addr_out, .arr0_out, .alu_out,
	.q0_full_out, .q0_empty_out, .q1_full_out, .q1_empty_out);

// [testbench/lt_cpu_model.sv]
// CPU or DMA master of the tile's register port.
// Assumes one-cycle request pulses answered by an ack one cycle later.
`timescale 1ns/1ps
module lt_cpu_model (
	input wire logic clk_in,
	input wire logic bus_ack_in,
	input wire logic [7:0] bus_rdata_in,
	output logic bus_wr_out,
	output logic bus_rd_out,
	output logic [3:0] bus_sel_out,
	output logic [7:0] bus_wdata_out
);
	initial begin
		bus_wr_out = 1'b0;
		bus_rd_out = 1'b0;
		bus_sel_out = 4'h0;
		bus_wdata_out = 8'h00;
	end
	// One access; released write data shows its inverse.
	task automatic xfer(input logic w, input logic [3:0] s, input logic [7:0] d,
		output logic [7:0] r, output logic a);
		@(posedge clk_in);
		#1;
		bus_wr_out = w;
		bus_rd_out = !w;
		bus_sel_out = s;
		bus_wdata_out = d;
		@(posedge clk_in);
		#1;
		a = bus_ack_in;
		r = bus_rdata_in;
		bus_wr_out = 1'b0;
		bus_rd_out = 1'b0;
		bus_wdata_out = ~d;
	endtask
endmodule // lt_cpu_model

// [testbench/lt_tile_bench.sv]
// Self-checking bench for the logic tile with a reference model in queues.
// Assumes lt_tile, lt_cpu_model and the bound checker are compiled first.
`timescale 1ns/1ps
module lt_tile_bench;
	logic clk_in, rst_in, tile_clk_en_in, tile_rst_in, reg_out_cfg_in, cfg_wr_in;
	logic [11:0] arr0_in, arr1_in, um, im;
	logic [2:0] route_addr_in, pin_addr_in, cfg_waddr_in, cfg_addr_out;
	logic [1:0] addr_src_in;
	logic [7:0] pt_wr_in, or_cfg_in, bus_wdata_in, bus_rdata_out, alu_out, a, b, v;
	logic [3:0] pt_idx_in, bus_sel_in, arr0_out, arr1_out;
	logic [23:0] pt_cfg_in;
	logic [15:0] cfg_wdata_in;
	logic bus_wr_in, bus_rd_in, bus_ack_out, cmp_eq_out, cmp_lt_out, zero_out;
	logic q0_full_out, q0_empty_out, q1_full_out, q1_empty_out;
	logic [7:0] acc [2];
	logic [7:0] dat [2];
	logic [7:0] q0 [$];
	logic [7:0] q1 [$];
	logic [31:0] seed = 32'h0001_849f;
	int error_cnt = 0;
	int checked = 0;
	lt_tile i_lt_tile (.clk_in, .rst_in, .tile_clk_en_in, .tile_rst_in, .arr0_in, .arr1_in,
		.route_addr_in, .pin_addr_in, .addr_src_in, .pt_wr_in, .pt_idx_in, .pt_cfg_in,
		.or_cfg_in, .reg_out_cfg_in, .cfg_wr_in, .cfg_waddr_in, .cfg_wdata_in, .bus_wr_in,
		.bus_rd_in, .bus_sel_in, .bus_wdata_in, .bus_rdata_out, .bus_ack_out, .arr0_out,
		.arr1_out, .alu_out, .cfg_addr_out, .cmp_eq_out, .cmp_lt_out, .zero_out,
		.q0_full_out, .q0_empty_out, .q1_full_out, .q1_empty_out);
	lt_cpu_model i_lt_cpu_model (.clk_in, .bus_ack_in(bus_ack_out),
		.bus_rdata_in(bus_rdata_out), .bus_wr_out(bus_wr_in), .bus_rd_out(bus_rd_in),
		.bus_sel_out(bus_sel_in), .bus_wdata_out(bus_wdata_in));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] alu(input logic [2:0] op, input logic [7:0] x, y);
		case (op)
			3'h1: return x + 8'h01;
			3'h2: return x - 8'h01;
			3'h3: return x + y;
			3'h4: return x - y;
			3'h5: return x & y;
			3'h6: return x | y;
			3'h7: return x ^ y;
			default: return x;
		endcase
	endfunction
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xs(input logic w, input logic [3:0] s, input logic [7:0] d,
		input logic [7:0] e);
		logic [7:0] r;
		logic k;
		i_lt_cpu_model.xfer(w, s, d, r, k);
		chk({7'h00, k}, 8'h01);
		if (!w)
			chk(r, e);
	endtask
	task automatic edge1();
		@(posedge clk_in);
		#1;
	endtask
	task automatic cfg(input logic [2:0] ad, input logic [15:0] w);
		edge1();
		cfg_wr_in = 1'b1;
		cfg_waddr_in = ad;
		cfg_wdata_in = w;
		edge1();
		cfg_wr_in = 1'b0;
	endtask
	task automatic step(input logic [2:0] ad);
		edge1();
		route_addr_in = ad;
		#1;
		chk({5'h00, cfg_addr_out}, {5'h00, ad});
		edge1();
		route_addr_in = 3'h0;
	endtask
	task automatic pt(input logic [3:0] idx, input logic [23:0] c, input logic [7:0] o);
		edge1();
		pt_wr_in = 8'h11;
		pt_idx_in = idx;
		pt_cfg_in = c;
		or_cfg_in = o;
		edge1();
		pt_wr_in = 8'h00;
	endtask
	initial begin
		{tile_rst_in, reg_out_cfg_in, cfg_wr_in, arr0_in, arr1_in, route_addr_in} = '0;
		{pin_addr_in, cfg_waddr_in, addr_src_in, pt_wr_in, pt_idx_in} = '0;
		{pt_cfg_in, or_cfg_in, cfg_wdata_in} = '0;
		tile_clk_en_in = 1'b1;
		rst_in = 1'b1;
		repeat (16) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		// Both queues empty; pass of a zero accumulator against a zero data register.
		xs(1'b0, lt_pkg::REG_STAT, 8'h00, 8'ha5);
		xs(1'b1, lt_pkg::REG_CTRL, 8'h01, 8'h00);
		for (int i = 0; i < 2; i++) begin
			acc[i] = rnd();
			dat[i] = rnd();
			xs(1'b1, lt_pkg::REG_ACC0 + 4'(i), acc[i], 8'h00);
			xs(1'b1, lt_pkg::REG_DAT0 + 4'(i), dat[i], 8'h00);
		end
		for (int i = 0; i < 2; i++) begin
			xs(1'b0, lt_pkg::REG_ACC0 + 4'(i), 8'h00, acc[i]);
			xs(1'b0, lt_pkg::REG_DAT0 + 4'(i), 8'h00, dat[i]);
		end
		$display("test registers done");
		for (int op = 0; op < 8; op++) begin
			v = rnd();
			a = v[0] ? acc[1] : acc[0];
			b = v[2:1] == 2'h0 ? dat[0] : v[2:1] == 2'h1 ? dat[1] : v[2:1] == 2'h2 ? acc[0] : acc[1];
			cfg(3'h1, {8'h00, 2'b10, v[2:1], v[0], 3'(op)});
			step(3'h1);
			acc[1] = alu(3'(op), a, b);
			chk(alu_out, acc[1]);
			chk({7'h00, zero_out}, {7'h00, acc[1] == 8'h00});
			xs(1'b0, lt_pkg::REG_ACC1, 8'h00, acc[1]);
			chk({6'h00, cmp_eq_out, cmp_lt_out}, {6'h00, acc[0] == dat[0], acc[0] < dat[0]});
		end
		$display("test alu done");
		for (int i = 0; i < 5; i++) begin
			v = rnd();
			xs(1'b1, lt_pkg::REG_Q0, v, 8'h00);
			if (q0.size() < 4)
				q0.push_back(v);
		end
		chk({7'h00, q0_full_out}, 8'h01);
		cfg(3'h2, 16'h1000);
		cfg(3'h3, 16'h2400);
		cfg(3'h4, 16'h2000);
		for (int i = 0; i < 4; i++) begin
			step(3'h2);
			dat[0] = q0.pop_front();
			xs(1'b0, lt_pkg::REG_DAT0, 8'h00, dat[0]);
		end
		chk({7'h00, q0_empty_out}, 8'h01);
		for (int i = 0; i < 5; i++) begin
			acc[0] = rnd();
			xs(1'b1, lt_pkg::REG_ACC0, acc[0], 8'h00);
			step(3'h3 + 3'(i % 2));
			if (q1.size() < 4)
				q1.push_back(acc[0]);
		end
		chk({7'h00, q1_full_out}, 8'h01);
		for (int i = 0; i < 5; i++)
			xs(1'b0, lt_pkg::REG_Q1, 8'h00, i < 4 ? q1.pop_front() : 8'h00);
		$display("test queues done");
		for (int i = 0; i < 8; i++) begin
			{um, im} = {rnd(), rnd(), rnd()};
			um = um | 12'h001;
			pt({1'b0, 3'(i)}, {im, um}, 8'h00);
			reg_out_cfg_in = v[0];
			pt({2'b10, 2'(i)}, {im, um}, 8'h01 << i);
			{arr0_in, arr1_in} = {rnd(), rnd(), rnd()};
			edge1();
			chk({7'h00, arr0_out[i % 4]}, {7'h00, &((arr0_in ^ im) | ~um)});
			chk({7'h00, arr1_out[i % 4]}, {7'h00, &((arr1_in ^ im) | ~um)});
			v = rnd();
		end
		$display("test arrays done");
		tile_rst_in = 1'b1;
		edge1();
		tile_rst_in = 1'b0;
		xs(1'b0, lt_pkg::REG_CTRL, 8'h00, 8'h01);
		xs(1'b0, lt_pkg::REG_ACC0, 8'h00, 8'h00);
		xs(1'b0, lt_pkg::REG_DAT1, 8'h00, 8'h00);
		// Entry 1 increments accumulator zero into accumulator one; stopped, nothing lands.
		cfg(3'h1, 16'h0081);
		tile_clk_en_in = 1'b0;
		step(3'h1);
		xs(1'b0, lt_pkg::REG_ACC1, 8'h00, 8'h00);
		tile_clk_en_in = 1'b1;
		$display("test tile reset and enable done");
		xs(1'b1, lt_pkg::REG_CTRL, 8'h00, 8'h00);
		xs(1'b1, lt_pkg::REG_ACC0, 8'h36, 8'h00);
		pin_addr_in = 3'h5;
		for (int s = 1; s < 4; s++) begin
			addr_src_in = 2'(s);
			repeat (5) edge1();
		end
		// Every entry but 1 passes accumulator zero, so the loop settles on entry 6.
		chk({5'h00, cfg_addr_out}, 8'h06);
		chk(alu_out, 8'h36);
		addr_src_in = 2'h2;
		repeat (5) edge1();
		chk({5'h00, cfg_addr_out}, 8'h05);
		$display("test address sources done");
		test_done();
	end
	initial begin
		#2000000;
		error_cnt++;
		$display("watchdog expired");
		test_done();
	end
endmodule // lt_tile_bench
